// *** rtl/intc_pkg.sv ***
// constants for the four-level interrupt priority controller
// assumes an apb master and a cpu core that acknowledges vectors and returns
package intc_pkg;
  localparam int NUM_SRC = 6;
  localparam int NUM_LVL = 4;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE = 8'ha8;
  localparam logic [7:0] IDX_PRIO_HI = 8'hb7;
  localparam logic [7:0] IDX_PRIO_LO = 8'hc0;
  localparam logic [7:0] IDX_TRIG = 8'hc1;
  localparam logic [7:0] IDX_FLAGS = 8'hc2;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hc3;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hc4;
  localparam int ADDR_W = 12;
  // enable register fields
  localparam int EN_GLOBAL_BIT = 7;
  localparam int EN_UNUSED_BIT = 6;
  localparam logic [7:0] EN_WMASK = 8'hbf;
  // trigger register fields
  localparam int TRIG_EXT0_BIT = 0;
  localparam int TRIG_EXT1_BIT = 1;
  // flags register: pending in 5:0, in-service levels in 11:8
  localparam int FLAGS_INSVC_LSB = 8;
  // source indexes in polling order
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SER = 4;
  localparam int SRC_TMR2 = 5;
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam logic [7:0] VEC_STEP = 8'h08;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [5:0] RST_PRIO = 6'h00;
  localparam logic [1:0] RST_TRIG = 2'h0;
  localparam logic [5:0] RST_IRQ = 6'h00;
endpackage : intc_pkg

// *** rtl/intc_arbiter.sv ***
// picks the highest-level request, lowest polling index on a tie
// assumes the request vector is already qualified by enables; priority vectors are not
`timescale 1ns/1ps
module intc_arbiter
  import intc_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  input wire logic [N-1:0] req_i,
  input wire logic [N-1:0] prio_hi_i,
  input wire logic [N-1:0] prio_lo_i,
  output logic valid_o,
  output logic [2:0] idx_o,
  output logic [1:0] lvl_o
);
  always_comb begin
    valid_o = 1'b0;
    idx_o = 3'h0;
    lvl_o = 2'h0;
    // descending scan with >= lets the lower index win a tie
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i] && (!valid_o || {prio_hi_i[i], prio_lo_i[i]} >= lvl_o)) begin
        valid_o = 1'b1;
        idx_o = 3'(i);
        lvl_o = {prio_hi_i[i], prio_lo_i[i]};
      end
    end
  end
endmodule : intc_arbiter

// *** rtl/intc_core.sv ***
// four-level nested interrupt controller with apb register access
// assumes the core pulses vector_ack_i when it jumps and reti_i on return
`timescale 1ns/1ps
module intc_core
  import intc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ext0_i,
  input wire logic ext1_i,
  input wire logic timer0_overflow_i,
  input wire logic timer1_overflow_i,
  input wire logic receive_done_flag_i,
  input wire logic transmit_done_flag_i,
  input wire logic timer2_overflow_flag_i,
  input wire logic timer2_external_flag_i,
  input wire logic vector_ack_i,
  input wire logic reti_i,
  output logic vector_req_o,
  output logic [7:0] vector_addr_o,
  output logic irq_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] vec_of(input logic [2:0] idx);
    vec_of = VEC_BASE + 8'({5'h00, idx} * VEC_STEP);
  endfunction : vec_of

  function automatic logic [1:0] top_of(input logic [3:0] set);
    top_of = 2'h0;
    for (int i = 0; i < NUM_LVL; i++) begin
      if (set[i]) begin
        top_of = 2'(i);
      end
    end
  endfunction : top_of

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic [7:0] interrupt_enable_mask_r;
  logic [5:0] priority_upper_bits_r;
  logic [5:0] priority_lower_bits_r;
  logic [1:0] trig_edge_r;
  logic [5:0] irq_stat_r;
  logic [5:0] irq_mask_r;
  logic [5:0] req_flag_r;
  logic [3:0] insvc_r;
  logic [2:0] grant_idx_r;
  logic [1:0] grant_lvl_r;
  logic req_r;
  logic [7:0] addr_r;
  logic [31:0] prdata_r;
  logic ext0_d_r;
  logic ext1_d_r;
  logic [7:0] reg_idx;
  logic wr_en;
  logic access;
  logic mapped;
  logic [5:0] pending;

  assign access = psel_i && penable_i;
  assign reg_idx = paddr_i[ADDR_W-3:2];
  assign wr_en = access && pwrite_i;
  assign mapped = (paddr_i[1:0] == 2'h0) && (reg_idx == IDX_ENABLE || reg_idx == IDX_PRIO_HI
    || reg_idx == IDX_PRIO_LO || reg_idx == IDX_TRIG || reg_idx == IDX_FLAGS
    || reg_idx == IDX_IRQ_STAT || reg_idx == IDX_IRQ_MASK);
  // zero wait states keep the core's sfr timing simple
  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign prdata_o = prdata_r;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (reg_idx)
        IDX_ENABLE: prdata_r <= {24'h000000, interrupt_enable_mask_r};
        IDX_PRIO_HI: prdata_r <= {26'h0000000, priority_upper_bits_r};
        IDX_PRIO_LO: prdata_r <= {26'h0000000, priority_lower_bits_r};
        IDX_TRIG: prdata_r <= {30'h00000000, trig_edge_r};
        IDX_FLAGS: prdata_r <= {20'h00000, insvc_r, 2'h0, pending};
        IDX_IRQ_STAT: prdata_r <= {26'h0000000, irq_stat_r};
        IDX_IRQ_MASK: prdata_r <= {26'h0000000, irq_mask_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      interrupt_enable_mask_r <= RST_ENABLE;
      priority_upper_bits_r <= RST_PRIO;
      priority_lower_bits_r <= RST_PRIO;
      trig_edge_r <= RST_TRIG;
      irq_mask_r <= RST_IRQ;
    end else if (wr_en && paddr_i[1:0] == 2'h0) begin
      case (reg_idx)
        IDX_ENABLE: interrupt_enable_mask_r <= pwdata_i[7:0] & EN_WMASK;
        IDX_PRIO_HI: priority_upper_bits_r <= pwdata_i[5:0];
        IDX_PRIO_LO: priority_lower_bits_r <= pwdata_i[5:0];
        IDX_TRIG: trig_edge_r <= pwdata_i[1:0];
        IDX_IRQ_MASK: irq_mask_r <= pwdata_i[5:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // request flags
  // ----------------------------------------
  logic [5:0] hw_set;
  logic [5:0] clr;
  logic [5:0] sw_clr;
  logic take;

  assign take = vector_ack_i && req_r;
  assign sw_clr = (wr_en && reg_idx == IDX_FLAGS && paddr_i[1:0] == 2'h0) ? pwdata_i[5:0] : 6'h00;
  assign hw_set[SRC_EXT0] = trig_edge_r[TRIG_EXT0_BIT] ? (ext0_i && !ext0_d_r) : ext0_i;
  assign hw_set[SRC_EXT1] = trig_edge_r[TRIG_EXT1_BIT] ? (ext1_i && !ext1_d_r) : ext1_i;
  assign hw_set[SRC_TMR0] = timer0_overflow_i;
  assign hw_set[SRC_TMR1] = timer1_overflow_i;
  assign hw_set[SRC_SER] = 1'b0;
  assign hw_set[SRC_TMR2] = 1'b0;

  always_comb begin
    clr = sw_clr;
    // level-mode externals follow the pin; vectoring leaves them alone
    if (!trig_edge_r[TRIG_EXT0_BIT]) clr[SRC_EXT0] = !ext0_i;
    if (!trig_edge_r[TRIG_EXT1_BIT]) clr[SRC_EXT1] = !ext1_i;
    if (take) begin
      if (grant_idx_r == 3'(SRC_TMR0) || grant_idx_r == 3'(SRC_TMR1)) begin
        clr[grant_idx_r] = 1'b1;
      end
      if ((grant_idx_r == 3'(SRC_EXT0) && trig_edge_r[TRIG_EXT0_BIT])
          || (grant_idx_r == 3'(SRC_EXT1) && trig_edge_r[TRIG_EXT1_BIT])) begin
        clr[grant_idx_r] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      req_flag_r <= 6'h00;
      ext0_d_r <= 1'b0;
      ext1_d_r <= 1'b0;
    end else begin
      req_flag_r <= (req_flag_r & ~clr) | hw_set;
      ext0_d_r <= ext0_i;
      ext1_d_r <= ext1_i;
    end
  end

  // serial and timer2 flags live in their own blocks; software clears them there
  assign pending = {timer2_overflow_flag_i | timer2_external_flag_i,
                    receive_done_flag_i | transmit_done_flag_i, req_flag_r[3:0]};

  // ----------------------------------------
  // arbitration and nesting
  // ----------------------------------------
  logic [5:0] eligible;
  logic win_valid;
  logic [2:0] win_idx;
  logic [1:0] win_lvl;
  logic [1:0] top_lvl;
  logic allowed;

  assign eligible = interrupt_enable_mask_r[EN_GLOBAL_BIT]
    ? (pending & interrupt_enable_mask_r[5:0]) : 6'h00;

  intc_arbiter #(.N(NUM_SRC)) u_arb (
    .req_i(eligible),
    .prio_hi_i(priority_upper_bits_r),
    .prio_lo_i(priority_lower_bits_r),
    .valid_o(win_valid),
    .idx_o(win_idx),
    .lvl_o(win_lvl)
  );

  assign top_lvl = top_of(insvc_r);
  assign allowed = win_valid && (insvc_r == 4'h0 || win_lvl > top_lvl);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      req_r <= 1'b0;
      addr_r <= 8'h00;
      grant_idx_r <= 3'h0;
      grant_lvl_r <= 2'h0;
    end else begin
      // drop for a cycle after ack or return so stale state is never offered
      req_r <= allowed && !vector_ack_i && !reti_i;
      addr_r <= vec_of(win_idx);
      grant_idx_r <= win_idx;
      grant_lvl_r <= win_lvl;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      insvc_r <= 4'h0;
    end else if (take) begin
      insvc_r <= insvc_r | (4'h1 << grant_lvl_r);
    end else if (reti_i && insvc_r != 4'h0) begin
      insvc_r <= insvc_r & ~(4'h1 << top_lvl);
    end
  end

  assign vector_req_o = req_r;
  assign vector_addr_o = addr_r;

  // ----------------------------------------
  // event status and interrupt line
  // ----------------------------------------
  logic [5:0] stat_set;
  logic [5:0] stat_clr;
  assign stat_set = take ? (6'h01 << grant_idx_r) : 6'h00;
  assign stat_clr = (wr_en && reg_idx == IDX_IRQ_STAT && paddr_i[1:0] == 2'h0)
    ? pwdata_i[5:0] : 6'h00;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      irq_stat_r <= RST_IRQ;
    end else begin
      irq_stat_r <= (irq_stat_r & ~stat_clr) | stat_set;
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_GLOBAL_OFF: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !$past(interrupt_enable_mask_r[EN_GLOBAL_BIT]) |-> !vector_req_o)
    else $error("vector offered while global enable low");
  AST_NO_EQUAL_NEST: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    vector_req_o |-> ($past(insvc_r) == 4'h0 || grant_lvl_r > $past(top_lvl)))
    else $error("vector offered under equal or higher level");
  AST_TAKE_FREE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (allowed && !vector_ack_i && !reti_i) |=> vector_req_o)
    else $error("takeable request not offered");
  AST_NEST_PUSH: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    take |=> insvc_r[$past(grant_lvl_r)] && (insvc_r & ~$past(insvc_r)) != 4'h0
      || $past(insvc_r[grant_lvl_r]))
    else $error("acknowledged level not marked in service");
  AST_RESTORE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (reti_i && !take && insvc_r[3] && insvc_r[0]) |=> insvc_r == ($past(insvc_r) & 4'h7))
    else $error("return did not restore lower level");
  AST_VECTOR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    vector_req_o |-> vector_addr_o == VEC_BASE + 8'({5'h00, grant_idx_r} * VEC_STEP))
    else $error("vector address mismatch");
  AST_TMR0_CLR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (take && grant_idx_r == 3'(SRC_TMR0) && !timer0_overflow_i) |=> !req_flag_r[SRC_TMR0])
    else $error("timer0 flag not cleared by vectoring");
  AST_LVL_EXT_KEEP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (take && grant_idx_r == 3'(SRC_EXT0) && !trig_edge_r[TRIG_EXT0_BIT] && ext0_i)
      |=> req_flag_r[SRC_EXT0])
    else $error("level external flag cleared by vectoring");
  AST_LEVEL_MAP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    win_valid |-> win_lvl == {priority_upper_bits_r[win_idx], priority_lower_bits_r[win_idx]})
    else $error("winner level not formed from priority bits");
  AST_SIX_SRC: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    win_valid |-> win_idx < 3'(NUM_SRC) && eligible[win_idx])
    else $error("winner outside the six sources");
  AST_UNUSED_ZERO: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !interrupt_enable_mask_r[EN_UNUSED_BIT])
    else $error("unimplemented enable bit set");
  AST_PRIO_HI_WR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (wr_en && reg_idx == IDX_PRIO_HI && paddr_i[1:0] == 2'h0)
      |=> priority_upper_bits_r == $past(pwdata_i[5:0]))
    else $error("upper priority write lost");
endmodule : intc_core

// *** tb/cpu_model.sv ***
// core-side model: acks a pending vector after a set delay, returns on command
// assumes the bench raises go_i to let it ack and pulses ret_i per return
`timescale 1ns/1ps
module cpu_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic vector_req_i,
  input wire logic go_i,
  input wire logic [3:0] delay_i,
  input wire logic ret_i,
  output logic vector_ack_o,
  output logic reti_o,
  output logic [7:0] ack_cnt_o
);
  logic [3:0] wait_r;
  // ack is a one-cycle pulse, never repeated while the request is low
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wait_r <= 4'h0;
      vector_ack_o <= 1'b0;
      ack_cnt_o <= 8'h00;
    end else if (vector_ack_o) begin
      vector_ack_o <= 1'b0;
      wait_r <= 4'h0;
      ack_cnt_o <= ack_cnt_o + 8'h01;
    end else if (vector_req_i && go_i) begin
      if (wait_r == delay_i) begin
        vector_ack_o <= 1'b1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      reti_o <= 1'b0;
    end else begin
      reti_o <= ret_i;
    end
  end
endmodule : cpu_model

// *** tb/tb_four_level_interrupt_priority.sv ***
// self-checking bench for the nested interrupt controller
// assumes the core model above and zero-wait apb access
`timescale 1ns/1ps
module tb_four_level_interrupt_priority;
  import intc_pkg::*;
  logic core_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, err;
  logic [ADDR_W-1:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, ext0_i, ext1_i, timer0_overflow_i, timer1_overflow_i;
  logic receive_done_flag_i, timer2_overflow_flag_i, vector_ack_i, reti_i;
  logic transmit_done_flag_i, timer2_external_flag_i;
  logic vector_req_o, irq_o, go, ret;
  logic [7:0] vector_addr_o, ack_cnt;
  logic [3:0] dly;
  int error_cnt, checks, cyc;
  intc_core uut (.core_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ext0_i, .ext1_i, .timer0_overflow_i,
    .timer1_overflow_i, .receive_done_flag_i, .transmit_done_flag_i,
    .timer2_overflow_flag_i, .timer2_external_flag_i, .vector_ack_i, .reti_i,
    .vector_req_o, .vector_addr_o, .irq_o);
  cpu_model core (.core_clk_i, .reset_n_i, .vector_req_i(vector_req_o), .go_i(go),
    .delay_i(dly), .ret_i(ret), .vector_ack_o(vector_ack_i), .reti_o(reti_i),
    .ack_cnt_o(ack_cnt));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // the whole run needs about 300 cycles
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {2'b00, idx, 2'b00};
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // only the bench timeout ends a stalled access
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task raise(input logic [5:0] m);
    @(posedge core_clk_i);
    ext0_i <= ext0_i | m[0];
    timer0_overflow_i <= m[1];
    ext1_i <= ext1_i | m[2];
    timer1_overflow_i <= m[3];
    receive_done_flag_i <= receive_done_flag_i | m[4];
    timer2_overflow_flag_i <= timer2_overflow_flag_i | m[5];
    @(posedge core_clk_i);
    timer0_overflow_i <= 1'b0;
    timer1_overflow_i <= 1'b0;
  endtask : raise
  task lower(input logic [5:0] m);
    @(posedge core_clk_i);
    ext0_i <= ext0_i & ~m[0];
    ext1_i <= ext1_i & ~m[2];
    receive_done_flag_i <= receive_done_flag_i & ~m[4];
    timer2_overflow_flag_i <= timer2_overflow_flag_i & ~m[5];
  endtask : lower
  task ret_one;
    @(posedge core_clk_i);
    ret <= 1'b1;
    @(posedge core_clk_i);
    ret <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask : ret_one
  // waits for a vector, checks its address, lets the core take it
  task take(input logic [7:0] exp, input logic [3:0] d);
    int k;
    logic [7:0] n;
    k = 0;
    while (vector_req_o !== 1'b1 && k < 30) begin
      @(posedge core_clk_i);
      k++;
    end
    chk({31'h0, vector_req_o}, 32'h1, "vector offered");
    chk({24'h0, vector_addr_o}, {24'h0, exp}, "vector address");
    n = ack_cnt;
    go <= 1'b1;
    dly <= d;
    k = 0;
    while (ack_cnt === n && k < 30) begin
      @(posedge core_clk_i);
      k++;
    end
    chk({31'h0, ack_cnt !== n}, 32'h1, "vector acknowledged");
    go <= 1'b0;
  endtask : take
  task idle;
    repeat (8) begin
      @(posedge core_clk_i);
      chk({31'h0, vector_req_o}, 32'h0, "request held back");
    end
  endtask : idle
  task insvc(input logic [3:0] exp);
    apb(1'b0, IDX_FLAGS, 32'h0);
    chk({28'h0, rd[11:8]}, {28'h0, exp}, "in-service levels");
  endtask : insvc
  task irq_is(input logic exp);
    @(negedge core_clk_i);
    chk({31'h0, irq_o}, {31'h0, exp}, "irq level");
  endtask : irq_is
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_n_i, psel_i, penable_i, pwrite_i, ext0_i, ext1_i, go, ret} = 8'h00;
    {timer0_overflow_i, timer1_overflow_i, receive_done_flag_i} = 3'h0;
    {timer2_overflow_flag_i, transmit_done_flag_i, timer2_external_flag_i} = 3'h0;
    paddr_i = '0;
    pwdata_i = 32'h0;
    dly = 4'h0;
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, IDX_ENABLE, 32'h0);
    chk(rd, 32'h0, "enable after reset");
    apb(1'b1, IDX_PRIO_HI, 32'h3f);
    apb(1'b0, IDX_PRIO_HI, 32'h0);
    chk(rd, 32'h3f, "upper priority readback");
    apb(1'b1, IDX_PRIO_HI, 32'h0);
    apb(1'b1, IDX_ENABLE, 32'hff);
    apb(1'b0, IDX_ENABLE, 32'h0);
    chk(rd, 32'hbf, "enable readback");
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped access");
    apb(1'b1, IDX_ENABLE, 32'h3f);
    raise(6'h02);
    idle;
    apb(1'b1, IDX_ENABLE, 32'hbf);
    take(8'h0b, 4'h3);
    ret_one;
    for (int i = 0; i < 6; i++) begin
      raise(6'h01 << i);
      take(8'(VEC_BASE + VEC_STEP * i), i[3:0]);
      apb(1'b0, IDX_FLAGS, 32'h0);
      chk({31'h0, rd[i]}, (i == 1 || i == 3) ? 32'h0 : 32'h1, "flag after vector");
      lower(6'h3f);
      ret_one;
    end
    apb(1'b1, IDX_TRIG, 32'h3);
    raise(6'h01);
    take(8'h03, 4'h0);
    apb(1'b0, IDX_FLAGS, 32'h0);
    chk({31'h0, rd[0]}, 32'h0, "edge flag cleared");
    lower(6'h3f);
    ret_one;
    apb(1'b1, IDX_TRIG, 32'h0);
    apb(1'b0, IDX_IRQ_STAT, 32'h0);
    chk(rd, 32'h3f, "irq status");
    irq_is(1'b0);
    apb(1'b1, IDX_IRQ_MASK, 32'h02);
    irq_is(1'b1);
    apb(1'b1, IDX_IRQ_STAT, 32'h02);
    irq_is(1'b0);
    // the other flag of each source pair raises the same request
    @(posedge core_clk_i);
    transmit_done_flag_i <= 1'b1;
    timer2_external_flag_i <= 1'b1;
    take(8'h23, 4'h0);
    transmit_done_flag_i <= 1'b0;
    ret_one;
    take(8'h2b, 4'h1);
    timer2_external_flag_i <= 1'b0;
    ret_one;
    apb(1'b1, IDX_PRIO_HI, 32'h20);
    apb(1'b1, IDX_PRIO_LO, 32'h10);
    raise(6'h30);
    take(8'h2b, 4'h0);
    insvc(4'h4);
    lower(6'h20);
    ret_one;
    take(8'h23, 4'h2);
    insvc(4'h2);
    lower(6'h10);
    ret_one;
    apb(1'b1, IDX_PRIO_HI, 32'h20);
    apb(1'b1, IDX_PRIO_LO, 32'h24);
    raise(6'h10);
    take(8'h23, 4'h0);
    raise(6'h20);
    take(8'h2b, 4'h0);
    insvc(4'h9);
    raise(6'h04);
    idle;
    lower(6'h20);
    ret_one;
    insvc(4'h1);
    take(8'h13, 4'h0);
    lower(6'h04);
    ret_one;
    lower(6'h10);
    ret_one;
    insvc(4'h0);
    report_and_stop;
  end
endmodule : tb_four_level_interrupt_priority
